// File: hw/clock_gate_ctl.v
// clock gate enable for one internal clock
// assumes an idle request from the block that owns the clock
`timescale 1ns/1ps
module clock_gate_ctl (
    input wire clk_i,
    input wire reset_n_i,
    input wire gate_off_i,
    input wire idle_i,
    output reg run_o
);
    // gate off forces the clock to follow its input
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_o <= 1'b1;
        end else begin
            run_o <= gate_off_i | ~idle_i;
        end
    end
endmodule

// File: hw/pm_misc_config_regs.v
// pm extension and miscellaneous configuration registers of a bus function
// assumes config cycles decoded upstream into a one-cycle read or write strobe
// assumes idle requests come from logic on this same clock
// the gating cells that use the run enables sit outside this block
//
// How it works
// - extension register is read-only zeros
// - power data byte reads zero
// - bridge extension byte reads zero
// - bit 15 feeds deep-off wake capability
// - bit 13 feeds light-sleep wake capability
// - bit 10 feeds light-sleep support capability
// - capability bits survive bus reset, d3-d0
// - bit 2 stops link clock gating
// - bit 1 stops bus clock gating
// - bit 0 drives KEEP_BUS_CLK_O only, not the bus run enable
// - reserved read-only bits read zero
// - bit 3 is plain storage, resets zero
// - wake field defaults 1100b, bit 13 programmable
// - capability bit 15 from misc register
`timescale 1ns/1ps
`include "pm_misc_defs.vh"
module pm_misc_config_regs (
    // clock and resets
    input wire CORE_CLK_I,
    input wire RESET_N_I,
    input wire BUS_RESET_N_I,
    // configuration access
    input wire CFG_RD_I,
    input wire CFG_WR_I,
    input wire [7:0] CFG_ADDR_I,
    input wire [3:0] CFG_BE_I,
    input wire [31:0] CFG_WDATA_I,
    output reg [31:0] CFG_RDATA_O,
    output reg CFG_ACK_O,
    // capability outputs
    output wire WAKE_FROM_DEEP_OFF_CAP_O,
    output wire [3:0] WAKE_STATE_SUPPORT_FIELD_O,
    output wire LIGHT_SLEEP_STATE_CAP_O,
    // clock control
    input wire LINK_IDLE_I,
    input wire BUS_IDLE_I,
    output wire LINK_CLK_RUN_O,
    output wire BUS_CLK_RUN_O,
    output wire KEEP_BUS_CLK_O
);
    ////////////////////////////////////////////////////////////////////////
    reg [31:0] misc;
    reg [31:0] next_misc;
    reg bus_rst_s1;
    reg bus_rst_s2;
    reg [31:0] byte_mask;
    integer i;
    wire [31:0] lane_wr_mask;
    wire bus_rst_active;
    wire cfg_strobe;

    // decode and read path
    reg misc_sel;
    reg ext_sel;
    wire misc_wr;
    wire misc_rd;
    wire ext_rd;
    wire [7:0] power_data_field;
    wire [7:0] bridge_extension_field;
    wire [15:0] pm_ext_value;
    wire [31:0] misc_view;
    reg [31:0] next_rdata;

    // named control bits
    wire wake_from_deep_off_cap;
    wire wake_from_light_sleep_cap;
    wire light_sleep_state_cap;
    wire link_clock_gate_off;
    wire bus_clock_gate_off;
    wire keep_bus_clk;
    // literals cannot be part-selected, so the constants get names
    localparam [15:0] ext_reset = `PM_EXT_RESET;
    localparam [1:0] wake_default_hi = `CAP_WAKE_HI;

    // bus reset is a pin, so it is synchronised first
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            bus_rst_s1 <= 1'b1;
            bus_rst_s2 <= 1'b1;
        end else begin
            bus_rst_s1 <= BUS_RESET_N_I;
            bus_rst_s2 <= bus_rst_s1;
        end
    end

    // bus reset counts only once it has crossed both flops
    assign bus_rst_active = ~bus_rst_s2;

    ////////////////////////////////////////////////////////////////////////
    // address decode by dword; the pm extension fills only the upper half of dword 0x48
    always @* begin
        misc_sel = 1'b0;
        ext_sel = 1'b0;
        if (CFG_ADDR_I == `MISC_CFG_OFFSET) begin
            misc_sel = 1'b1;
        end else if (CFG_ADDR_I == `PM_EXT_DWORD) begin
            ext_sel = 1'b1;
        end
    end
    assign misc_wr = CFG_WR_I & misc_sel;
    assign misc_rd = CFG_RD_I & misc_sel;
    assign ext_rd = CFG_RD_I & ext_sel;

    ////////////////////////////////////////////////////////////////////////
    // byte lanes, limited to the writable bits
    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            byte_mask[i*8 +: 8] = {8{CFG_BE_I[i]}};
        end
    end
    assign lane_wr_mask = byte_mask & `MISC_WR_MASK;

    always @* begin
        next_misc = misc;
        if (misc_wr) begin
            next_misc = (misc & ~lane_wr_mask) | (CFG_WDATA_I & lane_wr_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus reset leaves capability bits
    // power-on resets all; bus reset only bits 3 to 0, spare bit 3 included
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            misc <= `MISC_CFG_RESET;
        end else if (bus_rst_active) begin
            misc[`BIT_SPARE] <= 1'b0;
            misc[`BIT_LINK_GATE_OFF] <= 1'b0;
            misc[`BIT_BUS_GATE_OFF] <= 1'b0;
            misc[`BIT_KEEP_BUS_CLK] <= 1'b0;
        end else begin
            misc <= next_misc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reserved bits read zero whatever is stored
    assign misc_view = {16'h0000, misc[`BIT_WAKE_DEEP_OFF], 1'b0,
        misc[`BIT_WAKE_LIGHT_SLEEP], 2'b00, misc[`BIT_LIGHT_SLEEP_CAP], 6'h00,
        misc[`BIT_SPARE], misc[`BIT_LINK_GATE_OFF], misc[`BIT_BUS_GATE_OFF],
        misc[`BIT_KEEP_BUS_CLK]};

    assign power_data_field = ext_reset[15:8];
    assign bridge_extension_field = ext_reset[7:0];
    assign pm_ext_value = {power_data_field, bridge_extension_field};

    // unmapped addresses and the low half of dword 0x48 read zero
    always @* begin
        next_rdata = 32'h00000000;
        if (misc_rd) begin
            next_rdata = misc_view;
        end else if (ext_rd) begin
            next_rdata = {pm_ext_value, 16'h0000};
        end
    end

    assign cfg_strobe = CFG_RD_I | CFG_WR_I;

    // one-cycle answer to every strobe
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            CFG_RDATA_O <= 32'h00000000;
            CFG_ACK_O <= 1'b0;
        end else begin
            CFG_ACK_O <= cfg_strobe;
            CFG_RDATA_O <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // named control bits, one per writable field except spare bit 3
    assign wake_from_deep_off_cap = misc[`BIT_WAKE_DEEP_OFF];
    assign wake_from_light_sleep_cap = misc[`BIT_WAKE_LIGHT_SLEEP];
    assign light_sleep_state_cap = misc[`BIT_LIGHT_SLEEP_CAP];
    assign link_clock_gate_off = misc[`BIT_LINK_GATE_OFF];
    assign bus_clock_gate_off = misc[`BIT_BUS_GATE_OFF];
    assign keep_bus_clk = misc[`BIT_KEEP_BUS_CLK];

    assign WAKE_FROM_DEEP_OFF_CAP_O = wake_from_deep_off_cap;
    // field default 1100b
    // hot-off state fixed on, light sleep programmable, two lowest off
    assign WAKE_STATE_SUPPORT_FIELD_O = {wake_default_hi[1],
        wake_from_light_sleep_cap, 2'b00};
    assign LIGHT_SLEEP_STATE_CAP_O = light_sleep_state_cap;
    assign KEEP_BUS_CLK_O = keep_bus_clk;

    ////////////////////////////////////////////////////////////////////////
    // run enables only; a busy owner keeps its clock whatever the bit
    // link and bus clock gate disable
    clock_gate_ctl link_gate (
        .clk_i(CORE_CLK_I),
        .reset_n_i(RESET_N_I),
        .gate_off_i(link_clock_gate_off),
        .idle_i(LINK_IDLE_I),
        .run_o(LINK_CLK_RUN_O)
    );
    clock_gate_ctl bus_gate (
        .clk_i(CORE_CLK_I),
        .reset_n_i(RESET_N_I),
        .gate_off_i(bus_clock_gate_off),
        .idle_i(BUS_IDLE_I),
        .run_o(BUS_CLK_RUN_O)
    );
endmodule

// File: hw/pm_misc_defs.vh
// register offsets, field positions and reset values for the pm extension
// and miscellaneous configuration registers
// assumes dword-aligned configuration addressing with byte enables
`ifndef PM_MISC_DEFS_VH
`define PM_MISC_DEFS_VH

`define PM_EXT_OFFSET 8'h4a
`define PM_EXT_DWORD 8'h48
`define PM_EXT_RESET 16'h0000
`define MISC_CFG_OFFSET 8'hf0
`define MISC_CFG_RESET 32'h00002400
`define MISC_WR_MASK 32'h0000a40f
`define BIT_WAKE_DEEP_OFF 15
`define BIT_WAKE_LIGHT_SLEEP 13
`define BIT_LIGHT_SLEEP_CAP 10
`define BIT_SPARE 3
`define BIT_LINK_GATE_OFF 2
`define BIT_BUS_GATE_OFF 1
`define BIT_KEEP_BUS_CLK 0
`define CAP_WAKE_HI 2'b11

`endif

// File: sim/cfg_host.sv
// host model: one-cycle config strobes
// assumes ack one cycle after the strobe
`timescale 1ns/1ps
module cfg_host (input wire clk_i, ack_i, input wire [31:0] rdata_i,
    output logic rd_o = 1'b0, wr_o = 1'b0, output logic [7:0] addr_o = 8'h00,
    output logic [31:0] wdata_o = 32'h0);
task automatic xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    @(posedge clk_i);
    {rd_o, wr_o, addr_o, wdata_o} <= {!w, w, a, d};
    @(posedge clk_i);
    {rd_o, wr_o} <= 2'b00;
    @(posedge clk_i);
    q = ack_i ? rdata_i : 32'hx;
    // stale data would hide a missed write
    wdata_o <= ~d;
endtask
endmodule

// File: sim/pm_misc_config_regs_properties.sv
// checker for the pm/misc register block
// sees only the block's ports
`timescale 1ns/1ps
module pm_misc_chk (
    input wire CORE_CLK_I, RESET_N_I, CFG_RD_I, CFG_WR_I, CFG_ACK_O,
    input wire [7:0] CFG_ADDR_I,
    input wire [31:0] CFG_RDATA_O,
    input wire [3:0] WAKE_STATE_SUPPORT_FIELD_O,
    input wire WAKE_FROM_DEEP_OFF_CAP_O, LIGHT_SLEEP_STATE_CAP_O,
    input wire LINK_CLK_RUN_O, BUS_CLK_RUN_O);
default clocking @(posedge CORE_CLK_I); endclocking
default disable iff (!RESET_N_I);
sequence rd_misc; CFG_RD_I && CFG_ADDR_I == 8'hf0; endsequence
chk_ack_follows: assert property ((CFG_RD_I || CFG_WR_I) |=> CFG_ACK_O)
    else $error("ack");
chk_ext_zero: assert property (CFG_RD_I && CFG_ADDR_I == 8'h48 |=>
    CFG_RDATA_O[31:16] == 16'h0) else $error("ext");
chk_rsvd_zero: assert property (rd_misc |=> (CFG_RDATA_O & 32'hffff5bf0) == 32'h0)
    else $error("rsvd");
chk_deep_cap: assert property (rd_misc |=> CFG_RDATA_O[15] == WAKE_FROM_DEEP_OFF_CAP_O)
    else $error("deep");
chk_wake_field: assert property (rd_misc |=>
    WAKE_STATE_SUPPORT_FIELD_O == {1'b1, CFG_RDATA_O[13], 2'b00}) else $error("field");
chk_light_cap: assert property (rd_misc |=> CFG_RDATA_O[10] == LIGHT_SLEEP_STATE_CAP_O)
    else $error("light");
chk_link_ungated: assert property (rd_misc ##1 CFG_RDATA_O[2] |-> LINK_CLK_RUN_O)
    else $error("link");
chk_bus_ungated: assert property (rd_misc ##1 CFG_RDATA_O[1] |-> BUS_CLK_RUN_O)
    else $error("bus");
endmodule
bind pm_misc_config_regs pm_misc_chk u_chk (.*);

// File: sim/pm_misc_config_regs_tb_top.sv
// bench for the pm/misc register block
// assumes cfg_host and the checker compiled first
`timescale 1ns/1ps
module pm_misc_config_regs_tb_top;
logic clk = 1'b0, rst_n = 1'b0, bus_rst_n = 1'b0;
logic link_idle = 1'b1, bus_idle = 1'b1;
logic [3:0] be = 4'hf;
wire rd, wr, ack, deep, light, lrun, brun, keep;
wire [7:0] addr;
wire [3:0] field;
wire [31:0] wdata, rdata;
wire [31:0] caps = {23'h0, deep, field, light, lrun, brun, keep};
logic [31:0] q;
int n_errors = 0, samples_checked = 0, cycles = 0;
always #2.5 clk = ~clk;
cfg_host host (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .rd_o(rd), .wr_o(wr),
    .addr_o(addr), .wdata_o(wdata));
pm_misc_config_regs DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .BUS_RESET_N_I(bus_rst_n),
    .CFG_RD_I(rd), .CFG_WR_I(wr), .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata),
    .CFG_RDATA_O(rdata), .CFG_ACK_O(ack), .WAKE_FROM_DEEP_OFF_CAP_O(deep),
    .WAKE_STATE_SUPPORT_FIELD_O(field), .LIGHT_SLEEP_STATE_CAP_O(light),
    .LINK_IDLE_I(link_idle), .BUS_IDLE_I(bus_idle), .LINK_CLK_RUN_O(lrun),
    .BUS_CLK_RUN_O(brun), .KEEP_BUS_CLK_O(keep));
task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        n_errors++;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic rd_cfg(logic [31:0] m, logic [31:0] c);
    host.xfer(1'b0, 8'hf0, 32'h0, q);
    check("misc", q, m);
    check("caps", caps, c);
endtask
task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
        n_errors++;
        complete_run;
    end
end
initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus_rst_n <= 1'b1;
    rd_cfg(32'h00002400, 32'h0c8);
    host.xfer(1'b1, 8'h48, 32'hffffffff, q);
    host.xfer(1'b0, 8'h48, 32'h0, q);
    check("ext", q & 32'hffff0000, 32'h0);
    $display("reset values done");
    host.xfer(1'b1, 8'hf0, 32'hffffffff, q);
    rd_cfg(32'h0000a40f, 32'h1cf);
    $display("all ones done");
    // idle inputs high, so clocks run only through the gate-off bits
    bus_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    bus_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_cfg(32'h0000a400, 32'h1c8);
    $display("bus reset done");
    host.xfer(1'b1, 8'hf0, 32'h0, q);
    rd_cfg(32'h0, 32'h080);
    $display("all zeros done");
    // busy owners keep both clocks running with the gate bits clear
    link_idle <= 1'b0;
    bus_idle <= 1'b0;
    rd_cfg(32'h0, 32'h086);
    link_idle <= 1'b1;
    bus_idle <= 1'b1;
    $display("busy owner done");
    // only lane 0 enabled: the capability byte must not move
    be <= 4'h1;
    host.xfer(1'b1, 8'hf0, 32'hffffffff, q);
    be <= 4'hf;
    rd_cfg(32'h0000000f, 32'h087);
    $display("byte lane done");
    // power-on reset in mid-run restores every default
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_cfg(32'h00002400, 32'h0c8);
    $display("power-on reset done");
    complete_run;
end
endmodule
